// ===== pkg/sub_pkg.sv
// Shared constants, register map and phase encoding of the subtract datapath
package sub_pkg;
	// Register byte offsets on the AHB-Lite bus
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_WORK  = 8'h04;
	localparam logic [7:0] OFF_STAT  = 8'h08;
	localparam logic [7:0] OFF_FADDR = 8'h0C;
	localparam logic [7:0] OFF_FDATA = 8'h10;
	// Command register fields
	localparam int CTRL_BORROW   = 0;
	localparam int CTRL_DEST     = 1;
	localparam int CTRL_ADDR_LSB = 8;
	// Status register fields
	localparam int FLAG_C      = 0;
	localparam int FLAG_NIBBLE = 1;
	localparam int FLAG_Z      = 2;
	localparam int FLAG_RANGE  = 3;
	localparam int STAT_BUSY   = 8;
	// Destination select encoding
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	// Reset values
	localparam logic [7:0]  WORK_RST  = 8'h00;
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic [7:0]  ADDR_RST  = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	// One instruction cycle spans four clocks
	localparam int PHASE_CYCLES = 4;
	// Phases of the instruction cycle
	typedef enum logic [2:0] {
		PH_IDLE    = 3'b000,
		PH_DECODE  = 3'b001,
		PH_READ    = 3'b010,
		PH_PROCESS = 3'b011,
		PH_WRITE   = 3'b100
	} phase_t;
endpackage

// ===== logic/sub_alu.sv
// Eight-bit subtractor with carry, nibble carry, zero and overflow outputs
`timescale 1ns/1ns
module sub_alu
	import sub_pkg::*;
(
	input  wire logic [7:0] file_val,
	input  wire logic [7:0] work_val,
	input  wire logic       borrow_mode,
	input  wire logic       carry_in,
	output logic      [7:0] diff,
	output logic            carry,
	output logic            nibble_carry,
	output logic            zero,
	output logic            range_flag
);
	logic [8:0] full_sum;
	logic [4:0] low_sum;
	logic       add_in;

	// Plain form adds one to complete the two's complement; borrow form uses the carry
	always_comb begin
		add_in       = borrow_mode ? carry_in : 1'b1;
		full_sum     = {1'b0, file_val} + {1'b0, ~work_val} + {8'h00, add_in};
		low_sum      = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + {4'h0, add_in};
		diff         = full_sum[7:0];
		carry        = full_sum[8];
		nibble_carry = low_sum[4];
		zero         = (full_sum[7:0] == 8'h00);
		range_flag   = (file_val[7] != work_val[7]) && (full_sum[7] != file_val[7]);
	end
endmodule

// ===== logic/ahb_reg_port.sv
// AHB-Lite slave front end that turns bus transfers into register accesses
`timescale 1ns/1ns
module ahb_reg_port
	import sub_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        busy,
	output logic             acc_stb,
	output logic             acc_write,
	output logic      [7:0]  acc_addr,
	output logic      [31:0] acc_wdata,
	input  wire logic [31:0] acc_rdata
);
	logic        pend;
	logic        next_pend;
	logic        next_readyout;
	logic [31:0] next_rdata;
	logic [7:0]  next_addr;
	logic        next_write;

	// Data phase waits while an instruction runs, so bus and sequencer never collide
	always_comb begin
		next_pend     = pend;
		next_readyout = hreadyout;
		next_rdata    = hrdata;
		next_addr     = acc_addr;
		next_write    = acc_write;
		acc_stb       = 1'b0;
		acc_wdata     = hwdata;
		if (pend) begin
			if (!busy) begin
				acc_stb       = 1'b1;
				next_pend     = 1'b0;
				next_readyout = 1'b1;
				if (!acc_write) begin
					next_rdata = acc_rdata;
				end
			end
		end else if (hsel && htrans[1] && hready) begin
			next_pend     = 1'b1;
			next_readyout = 1'b0;
			next_addr     = haddr[7:0];
			next_write    = hwrite;
		end
	end

	// Response is always OKAY; word size is the only one supported
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend      <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= RDATA_RST;
			acc_addr  <= ADDR_RST;
			acc_write <= 1'b0;
		end else begin
			pend      <= next_pend;
			hreadyout <= next_readyout;
			hresp     <= 1'b0;
			hrdata    <= next_rdata;
			acc_addr  <= next_addr;
			acc_write <= next_write;
		end
	end
endmodule

// ===== logic/sub_datapath.sv
// Register-file subtract datapath with working register, status flags and bus registers
`timescale 1ns/1ns
//
// Behaviour
// - The result is the addressed file register minus the working register, one more in borrow form with carry clear, in two's complement, eight bits wide.
// - Destination select 0 returns the result to the working register, 1 returns it to the file register.
// - Overflow, carry, nibble carry and zero are updated, carry meaning no borrow and zero a null result.
// - Each subtract is one word and one instruction cycle of decode, read, process and write phases.
module sub_datapath
	import sub_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata
);
	localparam int DEPTH = 1 << ADDR_W;

	phase_t              phase;
	phase_t              next_phase;
	logic                op_borrow;
	logic                next_op_borrow;
	logic                op_dest;
	logic                next_op_dest;
	logic [ADDR_W-1:0]   op_addr;
	logic [ADDR_W-1:0]   next_op_addr;
	logic [7:0]          opf;
	logic [7:0]          next_opf;
	logic [7:0]          opw;
	logic [7:0]          next_opw;
	logic [7:0]          res;
	logic [7:0]          next_res;
	logic [3:0]          res_flags;
	logic [3:0]          next_res_flags;
	logic [7:0]          working_register;
	logic [7:0]          next_working_register;
	logic [3:0]          flags;
	logic [3:0]          next_flags;
	logic [ADDR_W-1:0]   faddr;
	logic [ADDR_W-1:0]   next_faddr;
	logic [7:0]          file_mem [DEPTH];
	logic                mem_we;
	logic [ADDR_W-1:0]   mem_addr;
	logic [7:0]          mem_wdata;
	logic                busy;
	logic                acc_stb;
	logic                acc_write;
	logic [7:0]          acc_addr;
	logic [31:0]         acc_wdata;
	logic [31:0]         acc_rdata;
	logic                bus_wr;
	logic [7:0]          alu_diff;
	logic                alu_c;
	logic                alu_nibble;
	logic                alu_z;
	logic                alu_range;

	assign busy   = (phase != PH_IDLE);
	assign bus_wr = acc_stb && acc_write;

	// Bus front end; it holds off every access until the sequencer is idle
	ahb_reg_port u_port (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.busy      (busy),
		.acc_stb   (acc_stb),
		.acc_write (acc_write),
		.acc_addr  (acc_addr),
		.acc_wdata (acc_wdata),
		.acc_rdata (acc_rdata)
	);

	// Arithmetic works on the operands latched in the read phase
	sub_alu u_alu (
		.file_val     (opf),
		.work_val     (opw),
		.borrow_mode  (op_borrow),
		.carry_in     (flags[FLAG_C]),
		.diff         (alu_diff),
		.carry        (alu_c),
		.nibble_carry (alu_nibble),
		.zero         (alu_z),
		.range_flag   (alu_range)
	);

	// Register read mux; unmapped offsets read as zero
	always_comb begin
		acc_rdata = 32'h0000_0000;
		case (acc_addr)
			OFF_CTRL: begin
				acc_rdata[CTRL_BORROW] = op_borrow;
				acc_rdata[CTRL_DEST]   = op_dest;
				acc_rdata[CTRL_ADDR_LSB +: ADDR_W] = op_addr;
			end
			OFF_WORK: begin
				acc_rdata[7:0] = working_register;
			end
			OFF_STAT: begin
				acc_rdata[3:0]       = flags;
				acc_rdata[STAT_BUSY] = busy;
			end
			OFF_FADDR: begin
				acc_rdata[ADDR_W-1:0] = faddr;
			end
			OFF_FDATA: begin
				acc_rdata[7:0] = file_mem[faddr];
			end
			default: begin
				acc_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Instruction sequencer: a command write starts one four-phase cycle
	always_comb begin
		next_phase            = phase;
		next_op_borrow        = op_borrow;
		next_op_dest          = op_dest;
		next_op_addr          = op_addr;
		next_opf              = opf;
		next_opw              = opw;
		next_res              = res;
		next_res_flags        = res_flags;
		next_working_register = working_register;
		next_flags            = flags;
		next_faddr            = faddr;
		case (phase)
			PH_IDLE: begin
				// Software writes land only here because the bus stalls otherwise
				if (bus_wr && acc_addr == OFF_CTRL) begin
					next_op_borrow = acc_wdata[CTRL_BORROW];
					next_op_dest   = acc_wdata[CTRL_DEST];
					next_op_addr   = acc_wdata[CTRL_ADDR_LSB +: ADDR_W];
					next_phase     = PH_DECODE;
				end
				if (bus_wr && acc_addr == OFF_WORK) begin
					next_working_register = acc_wdata[7:0];
				end
				if (bus_wr && acc_addr == OFF_STAT) begin
					next_flags = acc_wdata[3:0];
				end
				if (bus_wr && acc_addr == OFF_FADDR) begin
					next_faddr = acc_wdata[ADDR_W-1:0];
				end
			end
			PH_DECODE: begin
				next_phase = PH_READ;
			end
			PH_READ: begin
				next_opf   = file_mem[op_addr];
				next_opw   = working_register;
				next_phase = PH_PROCESS;
			end
			PH_PROCESS: begin
				next_res                    = alu_diff;
				next_res_flags[FLAG_C]      = alu_c;
				next_res_flags[FLAG_NIBBLE] = alu_nibble;
				next_res_flags[FLAG_Z]      = alu_z;
				next_res_flags[FLAG_RANGE]  = alu_range;
				next_phase                  = PH_WRITE;
			end
			PH_WRITE: begin
				// Flags always come from the result, even when the destination is the file
				next_flags = res_flags;
				if (op_dest == DEST_WORK) begin
					next_working_register = res;
				end
				next_phase = PH_IDLE;
			end
			default: begin
				next_phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase            <= PH_IDLE;
			op_borrow        <= 1'b0;
			op_dest          <= DEST_WORK;
			op_addr          <= '0;
			opf              <= WORK_RST;
			opw              <= WORK_RST;
			res              <= WORK_RST;
			res_flags        <= FLAGS_RST;
			working_register <= WORK_RST;
			flags            <= FLAGS_RST;
			faddr            <= '0;
		end else begin
			phase            <= next_phase;
			op_borrow        <= next_op_borrow;
			op_dest          <= next_op_dest;
			op_addr          <= next_op_addr;
			opf              <= next_opf;
			opw              <= next_opw;
			res              <= next_res;
			res_flags        <= next_res_flags;
			working_register <= next_working_register;
			flags            <= next_flags;
			faddr            <= next_faddr;
		end
	end

	// File memory port: destination write or software data write, never both at once
	always_comb begin
		mem_we    = 1'b0;
		mem_addr  = faddr;
		mem_wdata = acc_wdata[7:0];
		if (phase == PH_WRITE && op_dest == DEST_FILE) begin
			mem_we    = 1'b1;
			mem_addr  = op_addr;
			mem_wdata = res;
		end else if (bus_wr && acc_addr == OFF_FDATA) begin
			mem_we = 1'b1;
		end
	end

	// No reset on the array: software must load file registers before use
	always_ff @(posedge hclk) begin
		if (mem_we) begin
			file_mem[mem_addr] <= mem_wdata;
		end
	end

	// Checking helpers
	logic       bterm;
	logic [7:0] exp_plain;
	logic [7:0] exp_borrow;
	logic       exp_nb;
	logic [7:0] exp_res;
	logic       exp_nibble;
	logic       exp_range;
	// Reference flags rebuilt from the operands, independent of the adder's carry chain
	always_comb begin
		bterm      = op_borrow && !flags[FLAG_C];
		exp_plain  = 8'(opf - opw);
		exp_borrow = 8'(opf - opw - 8'h01);
		exp_nb     = ({1'b0, opf} >= ({1'b0, opw} + {8'h00, bterm}));
		exp_res    = 8'(opf - opw - {7'h00, bterm});
		exp_nibble = ({1'b0, opf[3:0]} >= ({1'b0, opw[3:0]} + {4'h0, bterm}));
		exp_range  = (opf[7] != opw[7]) && (exp_res[7] != opf[7]);
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	phase_walk_a: assert property (
		(phase == PH_DECODE) |=> (phase == PH_READ) ##1 (phase == PH_PROCESS)
			##1 (phase == PH_WRITE) ##1 (phase == PH_IDLE))
		else $error("instruction cycle phases out of order");

	plain_diff_a: assert property (
		(phase == PH_PROCESS && !op_borrow) |=> (res == $past(exp_plain)))
		else $error("plain subtract result wrong");

	borrow_diff_a: assert property (
		(phase == PH_PROCESS && op_borrow && !flags[FLAG_C]) |=> (res == $past(exp_borrow)))
		else $error("borrow subtract did not take one more");

	dest_work_a: assert property (
		(phase == PH_WRITE && op_dest == DEST_WORK) |=> (working_register == $past(res)))
		else $error("working register not written");

	dest_file_a: assert property (
		(phase == PH_WRITE && op_dest == DEST_FILE)
			|=> (file_mem[$past(op_addr)] == $past(res)) && $stable(working_register))
		else $error("file register destination wrong");

	carry_flag_a: assert property (
		(phase == PH_PROCESS) |=> ##1 (flags[FLAG_C] == $past(exp_nb, 2)))
		else $error("carry flag does not match borrow");

	zero_flag_a: assert property (
		(phase == PH_WRITE) |=> (flags[FLAG_Z] == ($past(res) == 8'h00)))
		else $error("zero flag does not match result");

	nibble_flag_a: assert property (
		(phase == PH_PROCESS) |=> ##1 (flags[FLAG_NIBBLE] == $past(exp_nibble, 2)))
		else $error("nibble carry flag wrong");

	range_flag_a: assert property (
		(phase == PH_PROCESS) |=> ##1 (flags[FLAG_RANGE] == $past(exp_range, 2)))
		else $error("signed range flag wrong");

	borrow_keep_a: assert property (
		(phase == PH_PROCESS && op_borrow && flags[FLAG_C]) |=> (res == $past(exp_plain)))
		else $error("borrow form took one away with carry set");

	bus_stall_a: assert property (
		(phase == PH_DECODE) |-> !acc_stb [*4])
		else $error("bus access during instruction cycle");
endmodule

// ===== sim/core_bus_master.sv
// Bus master model standing in for the core's decoder and register file
`timescale 1ns/1ns
module core_bus_master
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	output logic             done,
	output logic      [31:0] rdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	logic [1:0]  st;
	logic [31:0] wd_q;

	// Idle, address phase, data phase; write data toggles when not owned so stale values never pass
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st     <= 2'h0;
			hsel   <= 1'b0;
			haddr  <= 32'h0000_0000;
			htrans <= 2'h0;
			hwrite <= 1'b0;
			hwdata <= 32'h0000_0000;
			wd_q   <= 32'h0000_0000;
			done   <= 1'b0;
			rdata  <= 32'h0000_0000;
		end else begin
			done <= 1'b0;
			case (st)
				2'h0: begin
					hwdata <= ~hwdata;
					if (start) begin
						hsel   <= 1'b1;
						htrans <= 2'h2;
						haddr  <= {24'h00_0000, addr};
						hwrite <= wr;
						wd_q   <= wdata;
						st     <= 2'h1;
					end
				end
				2'h1: if (hready) begin
					hsel   <= 1'b0;
					htrans <= 2'h0;
					hwdata <= hwrite ? wd_q : ~hwdata;
					st     <= 2'h2;
				end
				default: if (hready) begin
					rdata <= hrdata; // Read data taken at the completing edge
					done  <= 1'b1;
					st    <= 2'h0;
				end
			endcase
		end
	end
endmodule

// ===== sim/subtract_register_datapath_tb.sv
// Self-checking bench for the subtract datapath
`timescale 1ns/1ns
module subtract_register_datapath_tb;
	import sub_pkg::*;
	logic        hclk, hresetn, start, wr, done, hsel, hwrite, hreadyout, hresp;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	int          fails, n_compared, cyc;
	logic [7:0]  tf [6] = '{8'h03, 8'h02, 8'h01, 8'h19, 8'h1B, 8'h03};
	logic [7:0]  tw [6] = '{8'h02, 8'h02, 8'h02, 8'h0D, 8'h1A, 8'h0E};
	logic        tb [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic        tc [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

	sub_datapath u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));
	core_bus_master u_core (.hclk(hclk), .hresetn(hresetn), .start(start), .wr(wr), .addr(addr),
		.wdata(wdata), .done(done), .rdata(rdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

	// Free-running core clock
	initial hclk = 1'b0;
	always #20 hclk = ~hclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus transfer through the master model; the wait is bounded
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc = 0;
		start <= 1'b1;
		wr    <= w;
		addr  <= a;
		wdata <= d;
		@(posedge hclk);
		start <= 1'b0;
		while (done !== 1'b1 && cyc < 100) begin
			@(posedge hclk);
			cyc++;
		end
		q = rdata;
		chk({31'h0, done}, 32'h0000_0001); // A wait that runs out counts as a mismatch
		chk({31'h0, hresp}, 32'h0000_0000);
	endtask

	// Status, working and command registers must show their reset values after any reset
	task automatic chk_reset();
		bus(1'b0, OFF_STAT, 32'h0000_0000);
		chk(q, {28'h000_0000, FLAGS_RST});
		bus(1'b0, OFF_WORK, 32'h0000_0000);
		chk(q, {24'h00_0000, WORK_RST});
		bus(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_0000);
	endtask

	// Reference subtract: returns overflow, zero, nibble carry, carry above the difference
	function automatic logic [11:0] exp_sub(input logic [7:0] f, w, input logic bo, cin);
		logic [8:0] r;
		logic [4:0] n;
		logic       b;
		b = bo & ~cin;
		r = {1'b0, f} - {1'b0, w} - 9'(b);
		n = {1'b0, f[3:0]} - {1'b0, w[3:0]} - 5'(b);
		return {(f[7] != w[7]) && (r[7] != f[7]), r[7:0] == 8'h00, ~n[4], ~r[8], r[7:0]};
	endfunction

	// Load operands, run one instruction, read status, working register and file data back
	task automatic run_op(input logic [7:0] f, w, a, input logic bo, cin, dst);
		logic [3:0]  fl;
		logic [11:0] e;
		fl = {3'($urandom), cin};
		e  = exp_sub(f, w, bo, cin);
		bus(1'b1, OFF_FADDR, {24'h00_0000, a});
		bus(1'b1, OFF_FDATA, {24'h00_0000, f});
		bus(1'b1, OFF_WORK, {24'h00_0000, w});
		bus(1'b1, OFF_STAT, {28'h000_0000, fl});
		bus(1'b1, OFF_CTRL, {16'h0000, a, 6'h00, dst, bo});
		bus(1'b0, OFF_STAT, 32'h0000_0000);
		// An idle read takes four waits; an instruction longer than its four phases would stall it
		chk(32'(cyc), 32'h0000_0004);
		chk(q, {28'h000_0000, e[11:8]});
		bus(1'b0, OFF_WORK, 32'h0000_0000);
		chk(q, {24'h00_0000, dst ? w : e[7:0]});
		bus(1'b0, OFF_FDATA, 32'h0000_0000);
		chk(q, {24'h00_0000, dst ? e[7:0] : f});
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 1490 cycles
	initial begin
		#(40 * 20000);
		fails++;
		end_sim();
	end

	// Main sequence: reset, documented corner cases, random mix, unmapped access
	initial begin
		hresetn = 1'b0;
		start = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		fails = 0;
		n_compared = 0;
		void'($urandom(97));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_reset();
		$display("test reset_values done");
		for (int i = 0; i < 6; i++)
			run_op(tf[i], tw[i], 8'(i + 1), tb[i], tc[i], 1'(i));
		$display("test corner_cases done");
		for (int i = 0; i < 30; i++)
			run_op(8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
		$display("test random_ops done");
		// Reset again between transfers; the file array keeps its contents, the rest must clear
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_reset();
		$display("test mid_reset done");
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		bus(1'b0, 8'h20, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		$display("test unmapped done");
		end_sim();
	end
endmodule
